// [cbd_pkg.sv]
package cbd_pkg;

  // bus activity class of the current cycle
  typedef enum logic [2:0] {
    CC_FREE  = 3'h0,
    CC_FETCH = 3'h1,
    CC_READ  = 3'h2,
    CC_PUSH  = 3'h3,
    CC_POP   = 3'h4,
    CC_VECT  = 3'h5,
    CC_WRITE = 3'h6
  } cbd_cyc_t;

  // sequencer states, gray steps along fetch -> operand -> read; operand -> write flips two bits
  typedef enum logic [3:0] {
    ST_FETCH = 4'h0,
    ST_OPND  = 4'h1,
    ST_READ  = 4'h3,
    ST_WRITE = 4'h2,
    ST_CALC  = 4'h6,
    ST_REL   = 4'h7,
    ST_PUSH  = 4'h5,
    ST_POP   = 4'h4,
    ST_VHI   = 4'hC,
    ST_VLO   = 4'hD
  } cbd_state_t;

  typedef enum logic [3:0] {
    AM_INH, AM_IMM, AM_DIR, AM_EXT, AM_IX, AM_IX1, AM_IX2,
    AM_SP1, AM_SP2, AM_IXP, AM_IX1P, AM_REL
  } cbd_mode_t;

  typedef enum logic [3:0] {
    IC_ILLEGAL, IC_PREFIX, IC_ALU, IC_STORE, IC_BRANCH, IC_CBEQ,
    IC_JMP, IC_PUSH, IC_POP, IC_SWI, IC_RTI, IC_INH
  } cbd_class_t;

  // values follow the low opcode nibble of the register/memory columns
  typedef enum logic [3:0] {
    ALU_SUB = 4'h0, ALU_CMP = 4'h1, ALU_SBC = 4'h2, ALU_CPX = 4'h3,
    ALU_AND = 4'h4, ALU_BIT = 4'h5, ALU_LDA = 4'h6, ALU_STA = 4'h7,
    ALU_EOR = 4'h8, ALU_ADC = 4'h9, ALU_ORA = 4'hA, ALU_ADD = 4'hB,
    ALU_JMP = 4'hC, ALU_NEG = 4'hD, ALU_LDX = 4'hE, ALU_STX = 4'hF
  } cbd_alu_t;

  // condition flag positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;
  localparam int FLG_V = 7;
  localparam logic [7:0] FLAGS_ONES = 8'h60;
  localparam logic [7:0] FLAGS_RST  = 8'h68;

  // opcodes handled individually
  localparam logic [7:0] OPC_PAGE2    = 8'h9E;
  localparam logic [7:0] OPC_CBEQ_IX1P = 8'h61;
  localparam logic [7:0] OPC_CBEQ_IXP  = 8'h71;
  localparam logic [7:0] OPC_NEGA     = 8'h40;
  localparam logic [7:0] OPC_RTI      = 8'h80;
  localparam logic [7:0] OPC_SWI      = 8'h83;
  localparam logic [7:0] OPC_TAP      = 8'h84;
  localparam logic [7:0] OPC_TPA      = 8'h85;
  localparam logic [7:0] OPC_PULA     = 8'h86;
  localparam logic [7:0] OPC_PSHA     = 8'h87;
  localparam logic [7:0] OPC_CLC      = 8'h98;
  localparam logic [7:0] OPC_SEC      = 8'h99;
  localparam logic [7:0] OPC_CLI      = 8'h9A;
  localparam logic [7:0] OPC_SEI      = 8'h9B;
  localparam logic [7:0] OPC_NOP      = 8'h9D;

  // vectors and reset values
  localparam logic [7:0]  VEC_PAGE    = 8'hFF;
  localparam logic [7:0]  VEC_RST_LO  = 8'hFE;
  localparam logic [7:0]  VEC_SWI_LO  = 8'hFC;
  localparam logic [15:0] STACK_RST   = 16'h00FF;
  localparam logic [2:0]  SWI_FRAME   = 3'h5;

  // register port map
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_PC    = 4'h1;
  localparam logic [3:0] REG_FLAGS = 4'h2;
  localparam logic [3:0] REG_ACC   = 4'h3;
  localparam logic [3:0] REG_STACK = 4'h4;
  localparam logic [3:0] REG_STATE = 4'h5;
  localparam int CTRL_RUN = 0;
  localparam logic CTRL_RUN_RST = 1'b1;

endpackage : cbd_pkg

// [cbd_dec_if.sv]
`timescale 1ns/1ns
interface cbd_dec_if;
  import cbd_pkg::*;
  logic [7:0] opcode;
  logic       page2;
  cbd_class_t cls;
  cbd_mode_t  mode;
  logic [1:0] nbytes;
  cbd_alu_t   alu_op;

  modport dec  (input opcode, input page2, output cls, output mode, output nbytes, output alu_op);
  modport core (output opcode, output page2, input cls, input mode, input nbytes, input alu_op);
endinterface : cbd_dec_if

// [cbd_decode.sv]
`timescale 1ns/1ns
module cbd_decode (
  // decode request and result
  cbd_dec_if.dec bus
);
  import cbd_pkg::*;

  function automatic cbd_class_t mem_class(input logic [3:0] lo, input logic imm);
    if (lo == 4'h7 || lo == 4'hF) mem_class = imm ? IC_ILLEGAL : IC_STORE;
    else if (lo == 4'hC) mem_class = imm ? IC_ILLEGAL : IC_JMP;
    else if (lo == 4'hD) mem_class = IC_ILLEGAL;
    else mem_class = IC_ALU;
  endfunction : mem_class

  function automatic logic [1:0] mode_bytes(input cbd_mode_t m);
    unique case (m)
      AM_EXT, AM_IX2, AM_SP2:                 mode_bytes = 2'd2;
      AM_IMM, AM_DIR, AM_IX1, AM_SP1, AM_IX1P, AM_REL: mode_bytes = 2'd1;
      default:                                mode_bytes = 2'd0;
    endcase
  endfunction : mode_bytes

  wire [3:0] hi = bus.opcode[7:4];
  wire [3:0] lo = bus.opcode[3:0];
  wire       is_branch = (hi == 4'h2) || (hi == 4'h9 && lo < 4'h4);

  always_comb begin
    bus.cls    = IC_ILLEGAL;
    bus.mode   = AM_INH;
    bus.alu_op = cbd_alu_t'(lo);
    if (bus.page2) begin
      if ((hi == 4'hD || hi == 4'hE) && lo != 4'hC) begin // [RULE_13] [RULE_14]
        bus.cls  = mem_class(lo, 1'b0);
        bus.mode = (hi == 4'hD) ? AM_SP2 : AM_SP1;
      end
    end else if (bus.opcode == OPC_PAGE2) begin
      bus.cls = IC_PREFIX; // [RULE_16]
    end else if (hi >= 4'hA) begin
      bus.cls = mem_class(lo, hi == 4'hA);
      unique case (hi)
        4'hA:    bus.mode = AM_IMM;
        4'hB:    bus.mode = AM_DIR;
        4'hC:    bus.mode = AM_EXT;
        4'hD:    bus.mode = AM_IX2; // [RULE_11]
        4'hE:    bus.mode = AM_IX1;
        default: bus.mode = AM_IX;
      endcase
    end else if (is_branch) begin
      bus.cls  = IC_BRANCH;
      bus.mode = AM_REL;
    end else begin
      unique case (bus.opcode)
        OPC_CBEQ_IXP:  begin bus.cls = IC_CBEQ; bus.mode = AM_IXP;  end // [RULE_12]
        OPC_CBEQ_IX1P: begin bus.cls = IC_CBEQ; bus.mode = AM_IX1P; end
        OPC_NEGA:      begin bus.cls = IC_ALU;  bus.alu_op = ALU_NEG; end
        OPC_PSHA:      bus.cls = IC_PUSH;
        OPC_PULA:      bus.cls = IC_POP;
        OPC_SWI:       bus.cls = IC_SWI;
        OPC_RTI:       bus.cls = IC_RTI;
        OPC_TAP, OPC_TPA, OPC_CLC, OPC_SEC, OPC_CLI, OPC_SEI, OPC_NOP: bus.cls = IC_INH;
        default:       bus.cls = IC_ILLEGAL;
      endcase
    end
  end

  // rel and post-increment offsets are counted here too
  assign bus.nbytes = mode_bytes(bus.mode); // [RULE_09]

endmodule : cbd_decode

// [cbd_alu.sv]
`timescale 1ns/1ns
module cbd_alu (
  // operation and operands
  input  wire cbd_pkg::cbd_alu_t op,
  input  wire logic [7:0]        lhs,
  input  wire logic [7:0]        rhs,
  input  wire logic [7:0]        flags_in,
  // result
  output logic [7:0]             res,
  output logic [7:0]             flags_out,
  output logic                   wr_a,
  output logic                   wr_x
);
  import cbd_pkg::*;

  wire       sub   = op inside {ALU_SUB, ALU_CMP, ALU_SBC, ALU_CPX, ALU_NEG};
  wire       add   = op inside {ALU_ADD, ALU_ADC};
  wire [7:0] x     = (op == ALU_NEG) ? 8'h00 : lhs;
  // subtraction is x + ~y + 1, borrow is the inverted carry
  wire [7:0] y     = sub ? ~rhs : rhs; // [RULE_15]
  wire       cin   = sub ? ~((op == ALU_SBC) & flags_in[FLG_C]) : ((op == ALU_ADC) & flags_in[FLG_C]);
  wire [8:0] sum   = {1'b0, x} + {1'b0, y} + {8'h00, cin};
  wire [4:0] half  = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};

  always_comb begin
    unique case (op)
      ALU_AND, ALU_BIT: res = lhs & rhs;
      ALU_EOR:          res = lhs ^ rhs;
      ALU_ORA:          res = lhs | rhs;
      ALU_LDA, ALU_LDX: res = rhs;
      ALU_STA, ALU_STX: res = lhs;
      default:          res = sum[7:0];
    endcase
  end

  always_comb begin
    flags_out        = flags_in;
    flags_out[FLG_N] = res[7]; // [RULE_08]
    flags_out[FLG_Z] = (res == 8'h00);
    flags_out[FLG_V] = 1'b0;
    if (sub || add) begin
      flags_out[FLG_V] = (x[7] == y[7]) && (sum[7] != x[7]);
      flags_out[FLG_C] = sub ? ~sum[8] : sum[8];
    end
    if (add) flags_out[FLG_H] = half[4];
  end

  assign wr_a = op inside {ALU_SUB, ALU_SBC, ALU_AND, ALU_LDA, ALU_EOR, ALU_ADC, ALU_ORA, ALU_ADD, ALU_NEG};
  assign wr_x = (op == ALU_LDX);

endmodule : cbd_alu

// [cbd_core.sv]
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
// Function
// RULE_01: free cycle needs no bus, lasts one clock, performed as a read
// RULE_02: program fetch reads next program location and advances the counter by one
// RULE_03: operand read moves one byte from memory in one bus cycle
// RULE_04: operand write moves one byte to memory in one bus cycle
// RULE_05: push writes one byte at the stack location; longer saves repeat it
// RULE_06: pop reads one byte from the stack; longer restores repeat it
// RULE_07: vectors come from the top page, high byte first
// RULE_08: flags register holds overflow, half-carry, mask, negative, zero, carry
// RULE_09: operands after the opcode are one or two bytes by addressing mode
// RULE_10: relative branch adds one signed offset byte to the program counter
// RULE_11: indexed modes take no, byte or word offset added to index pair
// RULE_12: post-increment indexed modes access via index then increment it
// RULE_13: stack-relative mode adds a byte offset to the stack pointer
// RULE_14: stack-relative mode also adds a word offset to the stack pointer
// RULE_15: subtraction and negation use two's complement for results and flags
// RULE_16: second-page opcodes are only recognised after the page prefix byte
// RULE_17: each opcode maps to mode, byte count and its bus-cycle sequence
module cbd_core (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  // memory bus
  output logic [15:0]            mem_addr,
  output logic                   mem_rd,
  output logic                   mem_wr,
  output logic [7:0]             mem_wdata,
  input  wire logic [7:0]        mem_rdata,
  output cbd_pkg::cbd_cyc_t      cyc_class,
  // register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [15:0]            reg_rdata
);
  import cbd_pkg::*;

  cbd_state_t  state_q, state_d;
  logic [7:0]  a_q, a_d, flags_q, flags_d, opc_q, opc_d, tmp_q, tmp_d, vec_q, vec_d;
  logic [15:0] hx_q, hx_d, sp_q, sp_d, pc_q, pc_d, opnd_q, opnd_d, ea_q, ea_d;
  logic [2:0]  cnt_q, cnt_d;
  logic        page2_q, page2_d, run_q;
  logic [15:0] reg_rdata_q;

  function automatic logic [15:0] rel_target(input logic [15:0] pc, input logic [7:0] off);
    rel_target = pc + 16'h0001 + {{8{off[7]}}, off};
  endfunction : rel_target

  function automatic logic br_taken(input logic [4:0] c, input logic [7:0] f);
    logic base;
    logic nv;
    nv = f[FLG_N] ^ f[FLG_V];
    unique case (c[4:1])
      4'h0:    base = 1'b1;
      4'h1:    base = ~(f[FLG_C] | f[FLG_Z]);
      4'h2:    base = ~f[FLG_C];
      4'h3:    base = ~f[FLG_Z];
      4'h4:    base = ~f[FLG_H];
      4'h5:    base = ~f[FLG_N];
      4'h6:    base = ~f[FLG_I];
      4'h8:    base = ~nv;
      4'h9:    base = ~(f[FLG_Z] | nv);
      default: base = 1'b0;
    endcase
    br_taken = base ^ c[0];
  endfunction : br_taken

  function automatic logic [15:0] eff_addr(input cbd_mode_t m, input logic [15:0] o,
                                           input logic [15:0] hx, input logic [15:0] sp);
    unique case (m)
      AM_DIR:           eff_addr = {8'h00, o[7:0]};
      AM_IX, AM_IXP:    eff_addr = hx;
      AM_IX1, AM_IX1P:  eff_addr = hx + {8'h00, o[7:0]};
      AM_IX2:           eff_addr = hx + o;
      AM_SP1:           eff_addr = sp + {8'h00, o[7:0]};
      AM_SP2:           eff_addr = sp + o;
      default:          eff_addr = o;
    endcase
  endfunction : eff_addr

  // decoder sees the bus byte during fetch, the held opcode afterwards
  cbd_dec_if dec_bus ();
  cbd_decode u_decode (.bus(dec_bus.dec));

  wire fetch_st  = (state_q == ST_FETCH);
  assign dec_bus.opcode = fetch_st ? mem_rdata : opc_q;
  assign dec_bus.page2  = fetch_st ? (opc_q == OPC_PAGE2) : page2_q;

  wire [15:0] opnd_full = fetch_st ? 16'h0000 : {opnd_q[7:0], mem_rdata};
  wire [15:0] ea_now    = eff_addr(dec_bus.mode, opnd_full, hx_q, sp_q); // [RULE_11] [RULE_13] [RULE_14]
  wire        dispatch  = run_q && dec_bus.cls != IC_PREFIX &&
                          (fetch_st ? (dec_bus.nbytes == 2'd0) : (state_q == ST_OPND && cnt_q == 3'h1));

  // alu
  wire       lhs_is_x = dec_bus.alu_op inside {ALU_CPX, ALU_LDX, ALU_STX};
  wire [7:0] alu_lhs  = lhs_is_x ? hx_q[7:0] : a_q;
  wire [7:0] alu_rhs  = (dec_bus.alu_op == ALU_NEG) ? a_q : mem_rdata;
  logic [7:0] alu_res, alu_flags;
  logic       alu_wr_a, alu_wr_x;

  cbd_alu u_alu (
    .op        (dec_bus.alu_op),
    .lhs       (alu_lhs),
    .rhs       (alu_rhs),
    .flags_in  (flags_q),
    .res       (alu_res),
    .flags_out (alu_flags),
    .wr_a      (alu_wr_a),
    .wr_x      (alu_wr_x)
  );

  wire alu_now = dec_bus.mode inside {AM_IMM, AM_INH};
  wire alu_exec = run_q && (((dec_bus.cls == IC_ALU) && ((dispatch && alu_now) || state_q == ST_READ)) ||
                            ((dec_bus.cls == IC_STORE) && state_q == ST_WRITE));

  // interrupt frame: slot 1 flags, 2 acc, 3 index low, 4 pc high, 5 pc low
  wire [2:0] pop_slot = 3'h6 - cnt_q;
  wire [7:0] push_byte = (dec_bus.cls == IC_PUSH) ? a_q :
                         (cnt_q == 3'h5) ? pc_q[7:0] :
                         (cnt_q == 3'h4) ? pc_q[15:8] :
                         (cnt_q == 3'h3) ? hx_q[7:0] :
                         (cnt_q == 3'h2) ? a_q : flags_q;

  // bus drive
  always_comb begin
    mem_addr  = pc_q;
    mem_rd    = run_q;
    mem_wr    = 1'b0;
    mem_wdata = 8'h00;
    cyc_class = CC_FREE; // [RULE_01]
    unique case (state_q)
      ST_FETCH, ST_OPND, ST_REL: cyc_class = CC_FETCH;
      ST_READ:  begin mem_addr = ea_q; cyc_class = CC_READ; end // [RULE_03]
      ST_WRITE: begin
        mem_addr  = ea_q;
        mem_rd    = 1'b0;
        mem_wr    = run_q;
        mem_wdata = alu_res; // [RULE_04]
        cyc_class = CC_WRITE;
      end
      ST_PUSH:  begin
        mem_addr  = sp_q;
        mem_rd    = 1'b0;
        mem_wr    = run_q;
        mem_wdata = push_byte; // [RULE_05]
        cyc_class = CC_PUSH;
      end
      ST_POP:   begin mem_addr = sp_q + 16'h0001; cyc_class = CC_POP; end // [RULE_06]
      ST_VHI:   begin mem_addr = {VEC_PAGE, vec_q}; cyc_class = CC_VECT; end // [RULE_07]
      ST_VLO:   begin mem_addr = {VEC_PAGE, vec_q + 8'h01}; cyc_class = CC_VECT; end
      default:  ;
    endcase
  end

  // sequencer and datapath next values
  always_comb begin
    state_d = state_q;
    a_d     = a_q;
    flags_d = flags_q;
    hx_d    = hx_q;
    sp_d    = sp_q;
    pc_d    = pc_q;
    opc_d   = opc_q;
    opnd_d  = opnd_q;
    ea_d    = ea_q;
    tmp_d   = tmp_q;
    cnt_d   = cnt_q;
    page2_d = page2_q;
    vec_d   = vec_q;
    if (run_q) begin
      unique case (state_q)
        ST_VHI:   begin pc_d[15:8] = mem_rdata; state_d = ST_VLO; end // [RULE_07]
        ST_VLO:   begin pc_d[7:0] = mem_rdata; state_d = ST_FETCH; end
        ST_FETCH: begin
          pc_d    = pc_q + 16'h0001; // [RULE_02]
          opc_d   = mem_rdata;
          opnd_d  = 16'h0000;
          cnt_d   = {1'b0, dec_bus.nbytes};
          page2_d = dec_bus.page2; // [RULE_16]
          if (dec_bus.cls != IC_PREFIX && dec_bus.nbytes != 2'd0) state_d = ST_OPND; // [RULE_09]
        end
        ST_OPND:  begin
          pc_d   = pc_q + 16'h0001;
          opnd_d = {opnd_q[7:0], mem_rdata};
          cnt_d  = cnt_q - 3'h1;
        end
        ST_READ:  begin
          state_d = ST_FETCH;
          if (dec_bus.cls == IC_CBEQ) begin
            tmp_d   = mem_rdata;
            hx_d    = hx_q + 16'h0001; // [RULE_12]
            state_d = ST_REL;
          end
        end
        ST_REL:   begin
          pc_d    = (a_q == tmp_q) ? rel_target(pc_q, mem_rdata) : pc_q + 16'h0001; // [RULE_10]
          state_d = ST_FETCH;
        end
        ST_PUSH:  begin
          sp_d  = sp_q - 16'h0001; // [RULE_05]
          cnt_d = cnt_q - 3'h1;
          if (cnt_q == 3'h1) begin
            state_d = ST_FETCH;
            if (dec_bus.cls == IC_SWI) begin
              flags_d[FLG_I] = 1'b1;
              vec_d          = VEC_SWI_LO;
              state_d        = ST_VHI; // [RULE_17]
            end
          end
        end
        ST_POP:   begin
          sp_d  = sp_q + 16'h0001; // [RULE_06]
          cnt_d = cnt_q - 3'h1;
          if (dec_bus.cls == IC_POP) a_d = mem_rdata;
          else begin
            unique case (pop_slot)
              3'h1:    flags_d = mem_rdata | FLAGS_ONES;
              3'h2:    a_d = mem_rdata;
              3'h3:    hx_d[7:0] = mem_rdata;
              3'h4:    pc_d[15:8] = mem_rdata;
              default: pc_d[7:0] = mem_rdata;
            endcase
          end
          if (cnt_q == 3'h1) state_d = ST_FETCH;
        end
        default:  state_d = ST_FETCH; // write, free cycle and illegal codes
      endcase
      if (dispatch) begin // [RULE_17]
        ea_d    = ea_now;
        state_d = ST_FETCH;
        unique case (dec_bus.cls)
          IC_ALU:    if (!alu_now) state_d = ST_READ;
          IC_STORE:  state_d = ST_WRITE;
          IC_CBEQ:   state_d = ST_READ;
          IC_BRANCH: begin
            if (br_taken({opc_q[7], opc_q[3:0]}, flags_q)) pc_d = rel_target(pc_q, mem_rdata); // [RULE_10]
            state_d = ST_CALC;
          end
          IC_JMP:    pc_d = ea_now;
          IC_PUSH:   begin state_d = ST_PUSH; cnt_d = 3'h1; end
          IC_POP:    begin state_d = ST_POP;  cnt_d = 3'h1; end
          IC_SWI:    begin state_d = ST_PUSH; cnt_d = SWI_FRAME; end
          IC_RTI:    begin state_d = ST_POP;  cnt_d = SWI_FRAME; end
          IC_INH:    begin
            unique case (mem_rdata)
              OPC_TAP: flags_d = a_q | FLAGS_ONES;
              OPC_TPA: a_d = flags_q;
              OPC_CLC: flags_d[FLG_C] = 1'b0;
              OPC_SEC: flags_d[FLG_C] = 1'b1;
              OPC_CLI: flags_d[FLG_I] = 1'b0;
              OPC_SEI: flags_d[FLG_I] = 1'b1;
              default: ;
            endcase
          end
          default:   ;
        endcase
      end
      if (alu_exec) begin
        flags_d = alu_flags; // [RULE_08] [RULE_15]
        if (alu_wr_a) a_d = alu_res;
        if (alu_wr_x) hx_d[7:0] = alu_res;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_VHI;
      a_q     <= 8'h00;
      flags_q <= FLAGS_RST;
      hx_q    <= 16'h0000;
      sp_q    <= STACK_RST;
      pc_q    <= 16'h0000;
      opc_q   <= 8'h00;
      opnd_q  <= 16'h0000;
      ea_q    <= 16'h0000;
      tmp_q   <= 8'h00;
      cnt_q   <= 3'h0;
      page2_q <= 1'b0;
      vec_q   <= VEC_RST_LO;
    end else begin
      state_q <= state_d;
      a_q     <= a_d;
      flags_q <= flags_d;
      hx_q    <= hx_d;
      sp_q    <= sp_d;
      pc_q    <= pc_d;
      opc_q   <= opc_d;
      opnd_q  <= opnd_d;
      ea_q    <= ea_d;
      tmp_q   <= tmp_d;
      cnt_q   <= cnt_d;
      page2_q <= page2_d;
      vec_q   <= vec_d;
    end
  end

  // register port; halting freezes the sequencer between cycles
  wire [15:0] reg_mux = (reg_addr == REG_CTRL)  ? {15'h0000, run_q} :
                        (reg_addr == REG_PC)    ? pc_q :
                        (reg_addr == REG_FLAGS) ? {8'h00, flags_q} :
                        (reg_addr == REG_ACC)   ? {a_q, hx_q[7:0]} :
                        (reg_addr == REG_STACK) ? sp_q :
                        (reg_addr == REG_STATE) ? {9'h000, cyc_class, state_q} : 16'h0000;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      run_q       <= CTRL_RUN_RST;
      reg_rdata_q <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == REG_CTRL) run_q <= reg_wdata[CTRL_RUN];
      reg_rdata_q <= reg_rd ? reg_mux : 16'h0000;
    end
  end

  assign reg_rdata = reg_rdata_q;

endmodule : cbd_core

// [cbd_core_asserts.sv]
`timescale 1ns/1ns
module cbd_core_asserts (
  // clock and reset
  input wire logic              clock,
  input wire logic              resetn,
  // memory bus
  input wire logic [15:0]       mem_addr,
  input wire logic              mem_rd,
  input wire logic              mem_wr,
  input wire logic [7:0]        mem_wdata,
  input wire logic [7:0]        mem_rdata,
  input wire cbd_pkg::cbd_cyc_t cyc_class,
  // register port
  input wire logic [3:0]        reg_addr,
  input wire logic [15:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [15:0]       reg_rdata
);
  import cbd_pkg::*;
  logic run_q;
  // shadow of the run bit: a frozen sequencer keeps its class but drops both strobes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) run_q <= CTRL_RUN_RST;
    else if (reg_wr && reg_addr == REG_CTRL) run_q <= reg_wdata[CTRL_RUN];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_free_read;
    run_q && cyc_class == CC_FREE |-> mem_rd && !mem_wr;
  endproperty
  a_free_read: assert property (p_free_read) else $error("free cycle is not a read");
  property p_rd_cyc;
    run_q && cyc_class inside {CC_FETCH, CC_READ, CC_POP, CC_VECT} |-> mem_rd && !mem_wr;
  endproperty
  a_rd_cyc: assert property (p_rd_cyc) else $error("read class without read strobe");
  property p_wr_cyc;
    run_q && cyc_class inside {CC_WRITE, CC_PUSH} |-> mem_wr && !mem_rd;
  endproperty
  a_wr_cyc: assert property (p_wr_cyc) else $error("write class without write strobe");
  property p_push_step;
    (run_q && cyc_class == CC_PUSH) ##1 (run_q && cyc_class == CC_PUSH) |-> mem_addr == $past(mem_addr) - 16'h1;
  endproperty
  a_push_step: assert property (p_push_step) else $error("push address did not step down");
  property p_pop_step;
    (run_q && cyc_class == CC_POP) ##1 (run_q && cyc_class == CC_POP) |-> mem_addr == $past(mem_addr) + 16'h1;
  endproperty
  a_pop_step: assert property (p_pop_step) else $error("pop address did not step up");
  property p_vect_page;
    cyc_class == CC_VECT |-> mem_addr[15:8] == VEC_PAGE;
  endproperty
  a_vect_page: assert property (p_vect_page) else $error("vector read off the top page");
  property p_vect_order;
    (run_q && cyc_class == CC_VECT && !mem_addr[0]) ##1 run_q |-> cyc_class == CC_VECT && mem_addr == $past(mem_addr) + 16'h1;
  endproperty
  a_vect_order: assert property (p_vect_order) else $error("vector low byte not after high byte");
  property p_branch;
    (run_q && cyc_class == CC_FETCH && mem_rdata == 8'h20) ##1 (run_q && cyc_class == CC_FETCH)
      ##1 (run_q && cyc_class == CC_FREE) |-> mem_addr == $past(mem_addr) + 16'h1 + {{8{$past(mem_rdata[7])}}, $past(mem_rdata)};
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong");
  c_vect: cover property (cyc_class == CC_VECT ##1 cyc_class == CC_VECT);
  c_push: cover property (cyc_class == CC_PUSH ##1 cyc_class == CC_PUSH);
  c_pop: cover property (cyc_class == CC_POP ##1 cyc_class == CC_POP);
endmodule : cbd_core_asserts
bind cbd_core cbd_core_asserts u_cbd_core_asserts (.clock(clock), .resetn(resetn), .mem_addr(mem_addr),
  .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .cyc_class(cyc_class),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// [cbd_mem.sv]
`timescale 1ns/1ns
module cbd_mem (
  // clock
  input wire logic        clock,
  // memory bus
  input wire logic [15:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic [7:0]  mem_wdata,
  output logic [7:0]      mem_rdata
);
  logic [7:0] m [65536];
  initial foreach (m[i]) m[i] = 8'h00;
  // unselected bus shows the inverted byte so stale data never looks like a read
  assign mem_rdata = mem_rd ? m[mem_addr] : ~m[mem_addr];
  always @(posedge clock) begin
    if (mem_wr) m[mem_addr] <= mem_wdata;
  end
endmodule : cbd_mem

// [cbd_core_tb.sv]
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; $display("unexpected %0t got %h want %h", $time, a, e); end end
module cbd_core_tb;
  import cbd_pkg::*;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, mem_addr, d, p;
  logic        mem_rd, mem_wr;
  logic [7:0]  mem_wdata, mem_rdata;
  cbd_cyc_t    cyc_class;
  int          mismatches = 0;
  int          checked = 0;
  logic [7:0]  prog [25] = '{8'hA6, 8'h05, 8'h40, 8'hC7, 8'h20, 8'h00, 8'h87, 8'h83, 8'hA6, 8'h3C, 8'h9E,
                             8'hE7, 8'h01, 8'h86, 8'hF7, 8'h9E, 8'hD7, 8'h01, 8'h00, 8'h71, 8'h02,
                             8'hA6, 8'h00, 8'h20, 8'hFE};
  always #10 clock = ~clock;
  cbd_core u_cbd_core (.clock(clock), .resetn(resetn), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .cyc_class(cyc_class), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  cbd_mem u_cbd_mem (.clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // reads race the running program, so flags go first and the stack before any push
  task automatic t_reset;
    rd(REG_FLAGS, d);
    `CHK(d, {8'h00, FLAGS_RST})
    rd(REG_STACK, d);
    `CHK(d, STACK_RST)
    rd(REG_CTRL, d);
    `CHK(d, 16'h0001)
    rd(4'hF, d);
    `CHK(d, 16'h0000)
    $display("test reset done");
  endtask : t_reset
  // lda, nega, sta ext, psha, swi, rti, lda, sta sp1, pula, sta ix, sta sp2, cbeq x+ over lda #0, bra self
  task automatic t_program;
    repeat (60) @(posedge clock);
    `CHK(u_cbd_mem.m[16'h2000], 8'hFB)
    `CHK(u_cbd_mem.m[16'h00FE], 8'h08)
    `CHK(u_cbd_mem.m[16'h00FD], 8'h10)
    `CHK(u_cbd_mem.m[16'h00FB], 8'hFB)
    `CHK(u_cbd_mem.m[16'h00FA], 8'h6D)
    `CHK(u_cbd_mem.m[16'h00FF], 8'h3C)
    `CHK(u_cbd_mem.m[16'h0000], 8'h3C)
    `CHK(u_cbd_mem.m[16'h01FF], 8'h3C)
    rd(REG_ACC, d);
    `CHK(d, 16'h3C01)
    rd(REG_STACK, d);
    `CHK(d, 16'h00FF)
    rd(REG_FLAGS, d);
    `CHK(d, 16'h0069)
    rd(REG_PC, d);
    `CHK(d >= 16'h1017 && d <= 16'h1019, 1'b1)
    $display("test program done");
  endtask : t_program
  task automatic t_freeze;
    wr(REG_CTRL, 16'h0000);
    rd(REG_PC, p);
    repeat (4) @(posedge clock);
    #1;
    `CHK(mem_rd, 1'b0)
    `CHK(mem_wr, 1'b0)
    wr(REG_PC, 16'h0000);
    rd(REG_PC, d);
    `CHK(d, p)
    wr(REG_CTRL, 16'h0001);
    rd(REG_CTRL, d);
    `CHK(d, 16'h0001)
    $display("test freeze done");
  endtask : t_freeze
  initial begin
    #1;
    foreach (prog[i]) u_cbd_mem.m[16'h1000 + i] = prog[i];
    u_cbd_mem.m[16'h3000] = 8'h80;
    u_cbd_mem.m[16'hFFFC] = 8'h30;
    u_cbd_mem.m[16'hFFFD] = 8'h00;
    u_cbd_mem.m[16'hFFFE] = 8'h10;
    u_cbd_mem.m[16'hFFFF] = 8'h00;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    t_reset();
    t_program();
    t_freeze();
    conclude();
  end
  initial begin
    repeat (2000) @(posedge clock);
    mismatches++;
    conclude();
  end
endmodule : cbd_core_tb
